/* logic/scs_pkg.sv */
package scs_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] ADDR_MODE    = 3'h0;  // Mode: bit 0 = clock-synchronous
  localparam logic [2:0] ADDR_CONTROL = 3'h1;  // Control: enables and clock bits
  localparam logic [2:0] ADDR_STATUS  = 3'h2;  // Serial status
  localparam logic [2:0] ADDR_TXDATA  = 3'h3;  // Transmit holding register
  localparam logic [2:0] ADDR_RXDATA  = 3'h4;  // Receive holding register
  localparam logic [2:0] ADDR_DIV     = 3'h5;  // Bit-rate divider

  // Status field positions
  localparam int ST_TXE  = 7;
  localparam int ST_RXF  = 6;
  localparam int ST_OVR  = 5;
  localparam int ST_FRM  = 4;
  localparam int ST_PAR  = 3;
  localparam int ST_DONE = 2;
  localparam int ST_MPR  = 1;
  localparam int ST_MPT  = 0;
  localparam logic [7:0] STATUS_RESET = 8'h84;
  localparam logic [7:0] FLAG_MASK    = 8'hf8;  // Read-then-clear flags

  // Control field positions
  localparam int CT_TXIE = 7;
  localparam int CT_RXIE = 6;
  localparam int CT_TXON = 5;
  localparam int CT_RXON = 4;
  localparam int CT_CKX  = 1;
  localparam int CT_CKO  = 0;

  localparam int OVERSAMPLE = 16;  // External async clock per bit
  localparam logic [7:0] DIV_RESET = 8'h0f;

  // Clock-pin role
  typedef struct packed {
    logic use_ext;   // Bit clock comes from pin
    logic drive;     // Pin driven by us
  } scs_clk_role_t;

  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} scs_tx_state_t;
endpackage : scs_pkg

/* logic/scs_serial_unit.sv */
// How it works
// - Output-select used only async, internal clock.
// - Async 00: internal clock, pin ignored.
// - Async 01: drive bit-rate clock on pin.
// - Async external: pin clock is sixteen times.
// - Sync internal: always drive clock out.
// - Eight-bit status, flags in fixed order.
// - Status loads 84 hex on reset/standby.
// - Software clears flags only by zero after one-read.
// - Done, mp-rx read-only; mp-tx writable.
// - Tx-empty clears by armed zero or DMA write.
// - Tx-empty sets: reset, tx off, shift load.
// - Rx-full sets on good reception transfer.
// - Rx-full clears: reset, armed zero, DMA read.
// - Errors keep rx data/flag; receive enable bit is unused.
// - Reception while full: overrun, data dropped.
// - Transmission starts after data write, flag clear.
// - Rx-full interrupt gated by receive interrupt enable.
// - Tx interrupt drops on flag clear or disable.
`timescale 1ns/1ns
module scs_serial_unit #(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RESET,
  input  wire logic              STANDBY,
  // Register port
  input  wire logic [2:0]        REG_ADDR,
  input  wire logic [7:0]        REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic [7:0]             REG_RDATA,
  // DMA access
  input  wire logic              DMA_TX_WR,
  input  wire logic [DATA_W-1:0] DMA_TX_DATA,
  input  wire logic              DMA_RX_RD,
  // Received character from the receive shifter
  input  wire logic              RX_DONE,
  input  wire logic [DATA_W-1:0] RX_DATA,
  input  wire logic              RX_ERROR,
  // Serial pins
  input  wire logic              SCK_IN,
  output logic                   SCK_OUT,
  output logic                   SCK_OE,
  output logic                   TXD,
  // Interrupt requests
  output logic                   RX_FULL_IRQ,
  output logic                   TX_EMPTY_IRQ,
  // Bit clock enable for the shifters
  output logic                   BIT_TICK
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and wires
  logic                 sync_mode_reg;      // Clock-synchronous mode
  logic [7:0]           control_reg;        // Enables and clock bits
  logic [7:0]           status_reg;         // Serial status
  logic [7:0]           armed_reg;          // Flags read as one
  logic [7:0]           div_reg;            // Bit-rate divider
  logic [DATA_W-1:0]    tx_holding_reg;     // Transmit holding data
  logic [DATA_W-1:0]    tx_shift_reg;       // Transmit shift data
  logic [DATA_W-1:0]    rx_holding_reg;     // Receive holding data
  logic [7:0]           div_cnt_reg;        // Divider counter
  logic                 int_clk_reg;        // Internal pin clock level
  logic                 int_tick;           // Internal bit-rate enable
  logic [1:0]           sck_sync_reg;       // Pin synchroniser
  logic                 sck_last_reg;       // Previous synced level
  logic                 ext_edge;           // Rising pin edge
  logic [3:0]           ovs_cnt_reg;        // Async oversample count
  logic [3:0]           bit_cnt_reg;        // Transmit bit counter
  scs_pkg::scs_tx_state_t tx_state_reg;     // Transmit state
  scs_pkg::scs_clk_role_t role;             // Pin role
  logic                 wr_status;          // Software status write
  logic                 rd_status;          // Software status read
  logic                 load_shift;         // Holding to shift move
  logic                 rx_accept;          // Good reception transfer

  ////////////////////////////////////////////////////////////////////////
  // Clock-pin role decode
  function automatic scs_pkg::scs_clk_role_t clk_role(input logic sync_m,
                                                      input logic [7:0] ctl);
    scs_pkg::scs_clk_role_t r;
    r.use_ext = ctl[scs_pkg::CT_CKX];
    if (sync_m)
      r.drive = !ctl[scs_pkg::CT_CKX];
    else
      r.drive = !ctl[scs_pkg::CT_CKX] && ctl[scs_pkg::CT_CKO];
    return r;
  endfunction : clk_role

  // Mode order is software's duty; decode follows current values
  assign role = clk_role(sync_mode_reg, control_reg);

  assign wr_status = REG_WR && (REG_ADDR == scs_pkg::ADDR_STATUS);
  assign rd_status = REG_RD && (REG_ADDR == scs_pkg::ADDR_STATUS);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and edge detect
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      sck_sync_reg <= 2'h0;
      sck_last_reg <= 1'h0;
    end
    else
    begin
      sck_sync_reg <= {sck_sync_reg[0], SCK_IN};
      sck_last_reg <= sck_sync_reg[1];
    end
  end

  // Pin input only counts when external source chosen
  assign ext_edge = role.use_ext && sck_sync_reg[1] && !sck_last_reg;

  ////////////////////////////////////////////////////////////////////////
  // Internal bit-rate divider
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      div_cnt_reg <= 8'h0;
      int_clk_reg <= 1'h0;
    end
    else if (role.use_ext)
    begin
      // Idle while the pin supplies the clock
      div_cnt_reg <= 8'h0;
      int_clk_reg <= 1'h0;
    end
    else if (div_cnt_reg >= div_reg)
    begin
      div_cnt_reg <= 8'h0;
      int_clk_reg <= !int_clk_reg;
    end
    else
      div_cnt_reg <= div_cnt_reg + 8'h1;
  end

  // One bit per full period of the pin clock, so output equals bit rate
  assign int_tick = !role.use_ext && (div_cnt_reg >= div_reg) && int_clk_reg;

  ////////////////////////////////////////////////////////////////////////
  // External oversample: async pin clock is sixteen per bit
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
      ovs_cnt_reg <= 4'h0;
    else if (!role.use_ext || sync_mode_reg)
      ovs_cnt_reg <= 4'h0;
    else if (ext_edge)
      ovs_cnt_reg <= ovs_cnt_reg + 4'h1;
  end

  always_comb
  begin
    if (!role.use_ext)
      BIT_TICK = int_tick;
    else if (sync_mode_reg)
      BIT_TICK = ext_edge;
    else
      BIT_TICK = ext_edge && (ovs_cnt_reg == 4'(scs_pkg::OVERSAMPLE - 1));
  end

  // Pin drive; undefined async level is held low here
  assign SCK_OE  = role.drive;
  assign SCK_OUT = role.drive && int_clk_reg;

  ////////////////////////////////////////////////////////////////////////
  // Mode, control and divider registers
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      sync_mode_reg <= 1'h0;
      control_reg   <= 8'h0;
      div_reg       <= scs_pkg::DIV_RESET;
    end
    else if (REG_WR)
    begin
      case (REG_ADDR)
        scs_pkg::ADDR_MODE:    sync_mode_reg <= REG_WDATA[0];
        scs_pkg::ADDR_CONTROL: control_reg   <= REG_WDATA;
        scs_pkg::ADDR_DIV:     div_reg       <= REG_WDATA;
        default:               ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit holding register
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
      tx_holding_reg <= '0;
    else if (DMA_TX_WR)
      tx_holding_reg <= DMA_TX_DATA;
    else if (REG_WR && REG_ADDR == scs_pkg::ADDR_TXDATA)
      tx_holding_reg <= REG_WDATA[DATA_W-1:0];
  end

  // Shift starts when data is valid and shifter idle
  assign load_shift = control_reg[scs_pkg::CT_TXON] && !status_reg[scs_pkg::ST_TXE]
                      && tx_state_reg == scs_pkg::TX_IDLE && BIT_TICK;

  ////////////////////////////////////////////////////////////////////////
  // Transmit shifter: start bit, data LSB first, stop bit
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      tx_state_reg <= scs_pkg::TX_IDLE;
      tx_shift_reg <= '0;
      bit_cnt_reg  <= 4'h0;
      TXD          <= 1'h1;
    end
    else
    begin
      case (tx_state_reg)
        scs_pkg::TX_IDLE:
        begin
          TXD <= 1'h1;
          if (load_shift)
          begin
            tx_shift_reg <= tx_holding_reg;
            bit_cnt_reg  <= 4'h0;
            TXD          <= 1'h0;
            tx_state_reg <= scs_pkg::TX_SHIFT;
          end
        end
        scs_pkg::TX_SHIFT:
          if (BIT_TICK)
          begin
            if (bit_cnt_reg == 4'(DATA_W))
            begin
              TXD          <= 1'h1;
              tx_state_reg <= scs_pkg::TX_IDLE;
            end
            else
            begin
              TXD          <= tx_shift_reg[0];
              tx_shift_reg <= tx_shift_reg >> 1;
              bit_cnt_reg  <= bit_cnt_reg + 4'h1;
            end
          end
        default: tx_state_reg <= scs_pkg::TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive holding register
  // Errors and a full holding register leave holding data untouched
  assign rx_accept = RX_DONE && !RX_ERROR && !status_reg[scs_pkg::ST_RXF];

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
      rx_holding_reg <= '0;
    else if (rx_accept)
      rx_holding_reg <= RX_DATA;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read-arming: a flag read as one may then be cleared
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
      armed_reg <= 8'h0;
    else if (STANDBY)
      armed_reg <= 8'h0;
    else if (rd_status)
      armed_reg <= status_reg & scs_pkg::FLAG_MASK;
    else if (wr_status)
      armed_reg <= 8'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Status register; set wins over clear
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
      status_reg <= scs_pkg::STATUS_RESET;
    else if (STANDBY)
      status_reg <= scs_pkg::STATUS_RESET;
    else
    begin
      // Transmit empty
      if (!control_reg[scs_pkg::CT_TXON] || load_shift)
        status_reg[scs_pkg::ST_TXE] <= 1'h1;
      else if (DMA_TX_WR || (wr_status && armed_reg[scs_pkg::ST_TXE]
                             && !REG_WDATA[scs_pkg::ST_TXE]))
        status_reg[scs_pkg::ST_TXE] <= 1'h0;
      // Receive full
      if (rx_accept)
        status_reg[scs_pkg::ST_RXF] <= 1'h1;
      else if (DMA_RX_RD || (wr_status && armed_reg[scs_pkg::ST_RXF]
                             && !REG_WDATA[scs_pkg::ST_RXF]))
        status_reg[scs_pkg::ST_RXF] <= 1'h0;
      // Overrun
      if (RX_DONE && status_reg[scs_pkg::ST_RXF])
        status_reg[scs_pkg::ST_OVR] <= 1'h1;
      else if (wr_status && armed_reg[scs_pkg::ST_OVR] && !REG_WDATA[scs_pkg::ST_OVR])
        status_reg[scs_pkg::ST_OVR] <= 1'h0;
      // Framing and parity have no set source in this module; clear only
      for (int i = scs_pkg::ST_PAR; i <= scs_pkg::ST_FRM; i++)
        if (wr_status && armed_reg[i] && !REG_WDATA[i])
          status_reg[i] <= 1'h0;
      // Transmit multiprocessor bit freely writable
      if (wr_status)
        status_reg[scs_pkg::ST_MPT] <= REG_WDATA[scs_pkg::ST_MPT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt requests
  assign RX_FULL_IRQ  = status_reg[scs_pkg::ST_RXF] && control_reg[scs_pkg::CT_RXIE];
  assign TX_EMPTY_IRQ = status_reg[scs_pkg::ST_TXE] && control_reg[scs_pkg::CT_TXIE];

  ////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; layout fixed
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
      REG_RDATA <= 8'h0;
    else if (REG_RD)
    begin
      case (REG_ADDR)
        scs_pkg::ADDR_MODE:    REG_RDATA <= {7'h0, sync_mode_reg};
        scs_pkg::ADDR_CONTROL: REG_RDATA <= control_reg;
        scs_pkg::ADDR_STATUS:  REG_RDATA <= status_reg;
        scs_pkg::ADDR_TXDATA:  REG_RDATA <= 8'(tx_holding_reg);
        scs_pkg::ADDR_RXDATA:  REG_RDATA <= 8'(rx_holding_reg);
        scs_pkg::ADDR_DIV:     REG_RDATA <= div_reg;
        default:               REG_RDATA <= 8'h0;
      endcase
    end
    else
      REG_RDATA <= 8'h0;
  end

endmodule : scs_serial_unit

/* sim/scs_checker.sv */
`timescale 1ns/1ns
module scs_checker (
  // Clock and reset
  input wire logic       CORE_CLK,
  input wire logic       RESET,
  input wire logic       STANDBY,
  // Register port
  input wire logic [2:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  // Events and pins
  input wire logic       RX_DONE,
  input wire logic       SCK_OE,
  input wire logic       RX_FULL_IRQ,
  input wire logic       TX_EMPTY_IRQ,
  input wire logic       BIT_TICK
);
  logic [7:0] ctl_reg;   // Shadow of the control register
  logic       sync_reg;  // Shadow of the mode bit
  ////////////////////////////////////////////////////////////////
  // Shadows track software writes, so no design internals are needed
  always_ff @(posedge CORE_CLK or posedge RESET)
    if (RESET) ctl_reg <= 8'h00;
    else if (REG_WR && REG_ADDR == scs_pkg::ADDR_CONTROL) ctl_reg <= REG_WDATA;
  always_ff @(posedge CORE_CLK or posedge RESET)
    if (RESET) sync_reg <= 1'b0;
    else if (REG_WR && REG_ADDR == scs_pkg::ADDR_MODE) sync_reg <= REG_WDATA[0];
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  // Standby held across a status read
  sequence s_standby_rd;
    STANDBY ##1 (STANDBY && REG_RD && REG_ADDR == scs_pkg::ADDR_STATUS);
  endsequence
  // Settled pin settings get three cycles to take effect
  a_standby_load: assert property (s_standby_rd |=> REG_RDATA == scs_pkg::STATUS_RESET)
    else $error("status not at its standby value");
  a_sync_drive: assert property ((sync_reg && !ctl_reg[1])[*3] |-> SCK_OE)
    else $error("sync internal clock not driven");
  a_async_quiet: assert property ((!sync_reg && ctl_reg[1:0] == 2'b00)[*3] |-> !SCK_OE)
    else $error("async clock pin driven with output off");
  a_async_out: assert property ((!sync_reg && ctl_reg[1:0] == 2'b01)[*3] |-> SCK_OE)
    else $error("async clock output not driven");
  a_ext_input: assert property (ctl_reg[1][*3] |-> !SCK_OE)
    else $error("clock pin driven while external");
  a_rxirq_gate: assert property (RX_FULL_IRQ |-> ctl_reg[6])
    else $error("rx irq without its enable");
  a_rxirq_cause: assert property ($rose(RX_FULL_IRQ) |-> $past(RX_DONE) || $past(REG_WR))
    else $error("rx irq rose without reception or enable");
  a_txirq_gate: assert property (TX_EMPTY_IRQ |-> ctl_reg[7])
    else $error("tx irq without its enable");
  a_txirq_force: assert property ((!ctl_reg[5] && ctl_reg[7])[*2] |-> TX_EMPTY_IRQ)
    else $error("tx empty not forced with transmitter off");
  a_tick_single: assert property (BIT_TICK |=> !BIT_TICK)
    else $error("bit tick longer than one cycle");
endmodule : scs_checker

/* sim/scs_peer.sv */
`timescale 1ns/1ns
module scs_peer #(
  parameter int HALF_NS = 16  // Half of the 32 ns link period
) (
  // Control from the bench
  input wire logic       go,     // Rising edge starts a burst
  input wire logic [7:0] n_clk,  // Clock periods per burst
  // Link side
  output logic           sck,    // Clock onto the serial clock pin
  output logic           busy    // High while a burst runs
);
  // Bursts only; the line rests low between them, it never runs free
  initial
  begin
    sck = 1'b0;
    busy = 1'b0;
    forever
    begin
      @(posedge go);
      busy = 1'b1;
      #3;
      repeat (n_clk)
      begin
        #HALF_NS sck = 1'b1;
        #HALF_NS sck = 1'b0;
      end
      busy = 1'b0;
    end
  end
endmodule : scs_peer

/* sim/tb.sv */
`timescale 1ns/1ns
module tb;
  localparam logic [2:0] MD = scs_pkg::ADDR_MODE;
  localparam logic [2:0] CT = scs_pkg::ADDR_CONTROL;
  localparam logic [2:0] ST = scs_pkg::ADDR_STATUS;
  // Design ports
  logic       CORE_CLK, RESET, STANDBY, REG_WR, REG_RD, DMA_TX_WR, DMA_RX_RD;
  logic       RX_DONE, RX_ERROR, SCK_IN, SCK_OUT, SCK_OE, TXD;
  logic       RX_FULL_IRQ, TX_EMPTY_IRQ, BIT_TICK;
  logic [2:0] REG_ADDR;
  logic [7:0] REG_WDATA, REG_RDATA, DMA_TX_DATA, RX_DATA;
  // Bench state
  logic [7:0] exp_q[$];
  logic       rd_q, go, busy, sck_q;
  logic [7:0] n_clk, d;
  int         err_total, n_compared, ticks, cyc, seed, rises;
  scs_serial_unit #(.DATA_W(8)) dut_u (
    .CORE_CLK(CORE_CLK), .RESET(RESET), .STANDBY(STANDBY),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .DMA_TX_WR(DMA_TX_WR), .DMA_TX_DATA(DMA_TX_DATA),
    .DMA_RX_RD(DMA_RX_RD), .RX_DONE(RX_DONE), .RX_DATA(RX_DATA), .RX_ERROR(RX_ERROR),
    .SCK_IN(SCK_IN), .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE), .TXD(TXD),
    .RX_FULL_IRQ(RX_FULL_IRQ), .TX_EMPTY_IRQ(TX_EMPTY_IRQ), .BIT_TICK(BIT_TICK)
  );
  scs_peer peer_u (.go(go), .n_clk(n_clk), .sck(SCK_IN), .busy(busy));
  ////////////////////////////////////////////////////////////////
  initial
  begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e)
    begin
      err_total++;
      $display("BAD t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task results;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  // Bus cycles; a spare edge keeps strobes from being rewritten at once
  task wr(input logic [2:0] a, input logic [7:0] v);
    REG_ADDR <= a; REG_WDATA <= v; REG_WR <= 1'b1;
    @(posedge CORE_CLK); REG_WR <= 1'b0; @(posedge CORE_CLK);
  endtask : wr
  task rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    REG_ADDR <= a; REG_RD <= 1'b1;
    @(posedge CORE_CLK); REG_RD <= 1'b0; @(posedge CORE_CLK);
  endtask : rd
  task rx(input logic [7:0] v, input logic e);
    RX_DATA <= v; RX_ERROR <= e; RX_DONE <= 1'b1;
    @(posedge CORE_CLK); RX_DONE <= 1'b0; RX_ERROR <= 1'b0; @(posedge CORE_CLK);
  endtask : rx
  task burst(input logic [7:0] n);
    int g;
    ticks = 0; n_clk <= n; go <= 1'b1;
    @(posedge CORE_CLK); go <= 1'b0;
    for (g = 0; g < 3000 && busy !== 1'b0; g++) @(posedge CORE_CLK);
    repeat (8) @(posedge CORE_CLK);
  endtask : burst
  // Start bit, eight data bits LSB first, stop bit; one bit per tick
  task frame(input logic [7:0] v);
    logic [9:0] got;
    int g;
    for (g = 0; g < 400 && TXD !== 1'b0; g++) @(negedge CORE_CLK);
    got[0] = TXD;
    for (int i = 1; i < 10; i++)
    begin
      for (g = 0; g < 60 && BIT_TICK !== 1'b1; g++) @(negedge CORE_CLK);
      @(negedge CORE_CLK); got[i] = TXD;
    end
    chk(16'(got), {6'h00, 1'b1, v, 1'b0});
    @(posedge CORE_CLK);
  endtask : frame
  ////////////////////////////////////////////////////////////////
  // Watchers: read data stands only in the cycle after the strobe
  always @(posedge CORE_CLK) rd_q <= REG_RD;
  always @(posedge CORE_CLK) if (BIT_TICK === 1'b1) ticks++;
  // Rising edges of the driven pin clock, to hold against the bit rate
  always @(posedge CORE_CLK)
  begin
    sck_q <= SCK_OUT;
    if (SCK_OUT === 1'b1 && sck_q === 1'b0) rises++;
  end
  always @(negedge CORE_CLK)
    if (rd_q === 1'b1 && exp_q.size() > 0) chk({8'h00, REG_RDATA}, {8'h00, exp_q.pop_front()});
  always @(posedge CORE_CLK)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_total++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 99; err_total = 0; n_compared = 0; cyc = 0; go = 0; n_clk = 0; rises = 0;
    RESET = 1; STANDBY = 0; REG_WR = 0; REG_RD = 0; REG_ADDR = 0; REG_WDATA = 0;
    DMA_TX_WR = 0; DMA_RX_RD = 0; DMA_TX_DATA = 0; RX_DONE = 0; RX_ERROR = 0; RX_DATA = 0;
    repeat (2) @(posedge CORE_CLK);
    RESET <= 1'b0;
    @(posedge CORE_CLK);
    rd(ST, 8'h84);
    rd(3'h5, scs_pkg::DIV_RESET);
    wr(3'h6, 8'($random(seed)));
    rd(3'h6, 8'h00);
    wr(ST, 8'hff);
    rd(ST, 8'h85);
    wr(ST, 8'h00);
    rd(ST, 8'h84);
    $display("registers done");
    for (int m = 0; m < 2; m++)
      for (int c = 0; c < 4; c++)
      begin
        wr(MD, 8'(m));
        wr(CT, 8'(c));
        @(negedge CORE_CLK);
        chk(16'(SCK_OE), 16'(m ? !c[1] : (c == 1)));
        @(posedge CORE_CLK);
      end
    wr(MD, 8'h00); wr(CT, 8'h02); burst(8'd64);
    chk(16'(ticks), 16'd4);
    wr(MD, 8'h01); wr(CT, 8'h02); burst(8'd8);
    chk(16'(ticks), 16'd8);
    $display("clocking done");
    wr(MD, 8'h00); wr(3'h5, 8'h01); wr(CT, 8'ha1);
    rd(ST, 8'h84);
    d = 8'($random(seed));
    wr(3'h3, d); wr(ST, 8'h00);
    frame(d);
    // Divider of one gives a four-cycle pin period: ten of each in forty cycles
    @(negedge CORE_CLK);
    ticks = 0;
    rises = 0;
    repeat (40) @(negedge CORE_CLK);
    chk(16'(rises), 16'h000a);
    chk(16'(ticks), 16'h000a);
    @(posedge CORE_CLK);
    d = 8'($random(seed));
    DMA_TX_DATA <= d; DMA_TX_WR <= 1'b1;
    @(posedge CORE_CLK); DMA_TX_WR <= 1'b0;
    frame(d);
    rd(ST, 8'h84);
    $display("transmit done");
    wr(CT, 8'h80);
    @(negedge CORE_CLK);
    chk(16'(TX_EMPTY_IRQ), 16'h0001);
    @(posedge CORE_CLK);
    wr(CT, 8'h50);
    @(negedge CORE_CLK);
    chk(16'(TX_EMPTY_IRQ), 16'h0000);
    @(posedge CORE_CLK);
    d = 8'($random(seed));
    // A bad reception while empty must leave data and flags alone
    rx(~d, 1'b1);
    rd(ST, 8'h84);
    rd(3'h4, 8'h00);
    rx(d, 1'b0);
    rd(ST, 8'hc4);
    rd(3'h4, d);
    @(negedge CORE_CLK);
    chk(16'(RX_FULL_IRQ), 16'h0001);
    @(posedge CORE_CLK);
    rx(~d, 1'b0);
    rd(ST, 8'he4);
    rd(3'h4, d);
    wr(CT, 8'h40);
    rd(ST, 8'he4);
    wr(ST, 8'hff); wr(ST, 8'h00);
    rd(ST, 8'he4);
    DMA_RX_RD <= 1'b1;
    @(posedge CORE_CLK); DMA_RX_RD <= 1'b0;
    @(negedge CORE_CLK);
    chk(16'(RX_FULL_IRQ), 16'h0000);
    @(posedge CORE_CLK);
    rd(ST, 8'ha4);
    wr(ST, 8'h00);
    rd(ST, 8'h84);
    wr(ST, 8'h01); STANDBY <= 1'b1;
    @(posedge CORE_CLK);
    rd(ST, 8'h84);
    STANDBY <= 1'b0;
    rd(ST, 8'h84);
    $display("receive done");
    results();
  end
endmodule : tb
bind scs_serial_unit scs_checker chk_u (
  .CORE_CLK(CORE_CLK), .RESET(RESET), .STANDBY(STANDBY),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .RX_DONE(RX_DONE), .SCK_OE(SCK_OE),
  .RX_FULL_IRQ(RX_FULL_IRQ), .TX_EMPTY_IRQ(TX_EMPTY_IRQ), .BIT_TICK(BIT_TICK)
);
